// ==== rtl/tepc_pkg.sv ====
// Purpose: shared constants and types for the tape exerciser program control
// Assumes: 25 MHz system clock
// Notes: register map and timing counts live here only
package tepc_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int DEBOUNCE_MS = 25;
  localparam int LOAD_PULSE_US = 1;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
  localparam int LOAD_PULSE_CYC = (LOAD_PULSE_US * CLK_HZ + 999999) / 1000000;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ITEST_LSB = 2;
  localparam int CTRL_BKPT_LSB = 4;
  localparam logic [6:0] CTRL_RST = 7'h00;

  localparam int CMD_START_BIT = 0;
  localparam int CMD_MCLR_BIT = 1;

  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_INSTR_LSB = 4;
  localparam int STAT_BKPT_BIT = 6;
  localparam int STAT_WREPLY_BIT = 7;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_DSEEN_BIT = 9;

  // ----------------------------------------------------------------------
  // modes and encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_LOAD, MODE_STEP, MODE_RUN, MODE_SPARE} tepc_mode_type;
  typedef enum logic [1:0] {ITEST_OFF, ITEST_ON, ITEST_SS, ITEST_SPARE} tepc_itest_type;

  // instruction as {bit1, bit0}
  localparam logic [1:0] INSTR_REWIND = 2'h0;
  localparam logic [1:0] INSTR_FORWARD = 2'h3;
  localparam logic [1:0] INSTR_WRITE = 2'h1;
  localparam logic [1:0] INSTR_REVERSE = 2'h2;

  // pushbutton order on the button bus
  localparam int BTN_REWIND = 0;
  localparam int BTN_FORWARD = 1;
  localparam int BTN_WRITE = 2;
  localparam int BTN_REVERSE = 3;

  localparam int STORE_WORDS = 4;
  localparam int STORE_BITS = 4;

endpackage

// ==== rtl/tepc_store_if.sv ====
// Purpose: signals between the sequencer and the instruction store
// Assumes: single clock domain
// Notes: read port is continuous
`timescale 1ns/1ps
interface tepc_store_if;
  logic [1:0] addr;
  logic we;
  logic [3:0] wdata;
  logic [3:0] rdata;
  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// ==== rtl/tepc_store.sv ====
// Purpose: four words of four bits, two instructions per word
// Assumes: write strobe is high for whole load pulse
// Notes: read data follows the address at all times
`timescale 1ns/1ps
module tepc_store
(
  input wire logic clk,
  input wire logic rst_n,
  tepc_store_if.mem bus
);
  import tepc_pkg::*;

  logic [STORE_BITS-1:0] mem_q [STORE_WORDS];

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STORE_WORDS; i++)
        mem_q[i] <= 4'h0;
    end
    else if (bus.we)
      mem_q[bus.addr] <= bus.wdata; // [RQ6]
  end

  assign bus.rdata = mem_q[bus.addr]; // [RQ6]

endmodule

// ==== rtl/tepc_loader.sv ====
// Purpose: turns an instruction pushbutton press into one delayed load pulse
// Assumes: buttons already synchronised
// Notes: one pulse per press; release rearms
`timescale 1ns/1ps
module tepc_loader
#(
  parameter int DEBOUNCE_CYC = tepc_pkg::DEBOUNCE_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_mode,
  input wire logic [3:0] buttons,
  output logic load_we,
  output logic [1:0] load_code
);
  import tepc_pkg::*;

  logic [CNT_W-1:0] dly_q, dly_d;
  logic [7:0] pls_q, pls_d;
  logic done_q, done_d;
  logic [1:0] code_q, code_d;
  logic pressed;
  logic fire;
  logic [1:0] btn_code;

  // ----------------------------------------------------------------------
  // button decode
  // ----------------------------------------------------------------------
  assign pressed = load_mode && (|buttons); // [RQ10]
  // rewind drives neither bit
  assign btn_code[0] = buttons[BTN_FORWARD] | buttons[BTN_WRITE]; // [RQ9]
  assign btn_code[1] = buttons[BTN_FORWARD] | buttons[BTN_REVERSE]; // [RQ9]
  assign fire = pressed && !done_q && (dly_q == CNT_W'(DEBOUNCE_CYC - 1)); // [RQ10]

  assign dly_d = !pressed ? '0 : (done_q ? dly_q : dly_q + CNT_W'(1));
  assign done_d = pressed && (done_q || fire);
  assign pls_d = fire ? 8'(LOAD_PULSE_CYC) : (pls_q != 8'h00 ? pls_q - 8'h01 : 8'h00);
  assign code_d = fire ? btn_code : code_q;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dly_q <= '0;
      pls_q <= 8'h00;
      done_q <= 1'b0;
      code_q <= 2'h0;
    end
    else
    begin
      dly_q <= dly_d;
      pls_q <= pls_d;
      done_q <= done_d;
      code_q <= code_d;
    end
  end

  assign load_we = (pls_q != 8'h00); // [RQ10]
  assign load_code = code_q;

endmodule

// ==== rtl/tepc_top.sv ====
// Purpose: program control sequencer of a tape exerciser
// Assumes: transport and panel pins are asynchronous; APB on clk
// Notes: zero wait state APB slave
//
// Functional notes
// [RQ1] internal test: stop pulse ends read-type and rewind operations
// [RQ2] internal test write: end when write data appears then disappears
// [RQ3] stop pulse from oscillator output, only without write or write terminate
// [RQ4] oscillator starts on write set, or go without write in internal test
// [RQ5] step mode one instruction per start; run mode repeats after start
// [RQ6] store is four four-bit words, read port shows current word
// [RQ7] low address bits pick word, high bit picks instruction slot
// [RQ8] three-bit address counter, eight states, high bit marks second half
// [RQ9] encoding bit0,bit1: rewind 00, forward 11, write 10, reverse 01
// [RQ10] buttons only in load mode; 25 ms delay then 1 us write pulse
// [RQ11] load writes new slot plus fed back other slot unchanged
// [RQ12] internal test substitutes a simulated write reply
// [RQ13] reply sets on internal test, write, forward direction and go pulse
// [RQ14] reply lights lamp; with step 3 and reverse sets write terminate
// [RQ15] counter advances on end of operation off breakpoint, or start in load; the code holds it on end of operation while backspace is high
// [RQ16] breakpoint when address equals switches; end then clears counter
// [RQ17] counter wraps from last state to first
// [RQ18] selected instruction presented while counter holds an address
`timescale 1ns/1ps
module tepc_top
#(
  parameter int DEBOUNCE_CYC = tepc_pkg::DEBOUNCE_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] instr_buttons,
  input wire logic osc_out,
  input wire logic write_data_present,
  input wire logic write_ff_set,
  input wire logic write_term_run,
  input wire logic go_pulse,
  input wire logic direction_fwd,
  input wire logic time3,
  input wire logic backspace,
  input wire logic transport_eoo,
  input wire logic transport_write_reply,
  output logic osc_start,
  output logic stop_pulse,
  output logic end_of_op,
  output logic go_request,
  output logic [1:0] instruction,
  output logic [2:0] prog_addr,
  output logic breakpoint,
  output logic write_reply,
  output logic write_reply_lamp,
  output logic set_write_term
);
  import tepc_pkg::*;

  localparam int NSYNC = 14;

  tepc_store_if sbus();

  logic rst_s1_q, rst_n;
  logic [NSYNC-1:0] pin_s1_q, pin_s2_q, pin_prev_q;
  logic [3:0] btn_s;
  logic osc_s, wdp_s, wff_s, wterm_s, go_s, fwd_s, t3_s, bsp_s, teoo_s, trep_s;
  logic osc_rise, wff_rise, go_rise, teoo_rise, wdp_fall;
  logic [6:0] ctrl_q, ctrl_d;
  tepc_mode_type mode;
  tepc_itest_type itest;
  logic [2:0] bkpt_sw;
  logic wr_en, rd_en, hit_ctrl, hit_cmd, hit_stat, hit_any;
  logic start_cmd, mclr_cmd;
  logic [31:0] stat_word, rd_mux;
  logic [31:0] prdata_q, prdata_d;
  logic load_mode, itest_any, itest_on;
  logic [1:0] cur_instr, instr_q;
  logic is_write;
  logic stop_d, osc_start_d, eoo_d, wr_end;
  logic dseen_q, dseen_d;
  logic stop_q, osc_start_q, eoo_q, go_q, go_d;
  logic [2:0] addr_q, addr_d;
  logic bkpt_q, bkpt_d;
  logic rep_q, rep_d;
  logic rep_set, rep_clr;
  logic load_we;
  logic [1:0] load_code;

  typedef enum {SEQ_IDLE, SEQ_RUN} tepc_seq_type;
  tepc_seq_type seq_q, seq_d;

  // pick one instruction slot out of a store word
  function automatic logic [1:0] slot_sel(input logic [3:0] word, input logic hi);
    slot_sel = hi ? word[3:2] : word[1:0];
  endfunction

  // ----------------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_prev_q <= '0;
    end
    else
    begin
      pin_s1_q <= {instr_buttons, osc_out, write_data_present, write_ff_set, write_term_run,
                   go_pulse, direction_fwd, time3, backspace, transport_eoo,
                   transport_write_reply};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign {btn_s, osc_s, wdp_s, wff_s, wterm_s, go_s, fwd_s, t3_s, bsp_s, teoo_s, trep_s} =
    pin_s2_q;
  assign osc_rise = osc_s && !pin_prev_q[9];
  assign wdp_fall = !wdp_s && pin_prev_q[8];
  assign wff_rise = wff_s && !pin_prev_q[7];
  assign go_rise = go_s && !pin_prev_q[5];
  assign teoo_rise = teoo_s && !pin_prev_q[1];

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_cmd = (paddr == CMD_OFS);
  assign hit_stat = (paddr == STATUS_OFS);
  assign hit_any = hit_ctrl || hit_cmd || hit_stat;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign ctrl_d = (wr_en && hit_ctrl) ? pwdata[6:0] : ctrl_q;
  assign start_cmd = wr_en && hit_cmd && pwdata[CMD_START_BIT];
  assign mclr_cmd = wr_en && hit_cmd && pwdata[CMD_MCLR_BIT];
  assign mode = tepc_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign itest = tepc_itest_type'(ctrl_q[CTRL_ITEST_LSB +: 2]);
  assign bkpt_sw = ctrl_q[CTRL_BKPT_LSB +: 3];

  assign stat_word = {22'h0, dseen_q, (seq_q == SEQ_RUN), write_reply, bkpt_q,
                      instr_q, 1'b0, addr_q};
  assign rd_mux = hit_ctrl ? {25'h0, ctrl_q} : (hit_stat ? stat_word : 32'h00000000);
  assign prdata_d = rd_en ? rd_mux : prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = prdata_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RST;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // mode decode and current instruction
  // ----------------------------------------------------------------------
  assign load_mode = (mode == MODE_LOAD);
  assign itest_on = (itest == ITEST_ON);
  assign itest_any = (itest == ITEST_ON) || (itest == ITEST_SS);
  assign cur_instr = slot_sel(sbus.rdata, addr_q[2]); // [RQ7] [RQ18]
  assign is_write = (cur_instr == INSTR_WRITE);

  // ----------------------------------------------------------------------
  // stop pulse, oscillator start, end of operation
  // ----------------------------------------------------------------------
  assign stop_d = osc_rise && !wff_s && !wterm_s; // [RQ3]
  assign osc_start_d = wff_rise || (go_rise && !is_write && !wterm_s && itest_any); // [RQ4]
  assign wr_end = dseen_q && wdp_fall; // [RQ2]
  assign dseen_d = (itest_any && is_write && wdp_s) || (!go_rise && dseen_q && !wr_end);
  assign eoo_d = itest_any ? (is_write ? wr_end : stop_d) : teoo_rise; // [RQ1] [RQ2]

  // ----------------------------------------------------------------------
  // step and run sequencing
  // ----------------------------------------------------------------------
  always_comb
  begin
    seq_d = seq_q;
    go_d = 1'b0;
    case (seq_q)
      SEQ_IDLE:
      begin
        if (start_cmd && !load_mode)
        begin
          go_d = 1'b1; // [RQ5]
          if (mode == MODE_RUN)
            seq_d = SEQ_RUN;
        end
      end
      SEQ_RUN:
      begin
        if (mclr_cmd || mode != MODE_RUN)
          seq_d = SEQ_IDLE;
        else if (eoo_q)
          go_d = 1'b1; // [RQ5]
      end
      default:
        seq_d = SEQ_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // program address counter and breakpoint
  // ----------------------------------------------------------------------
  always_comb
  begin
    addr_d = addr_q;
    if (mclr_cmd)
      addr_d = 3'h0;
    else if (eoo_d && bkpt_q)
      addr_d = 3'h0; // [RQ16]
    else if ((eoo_d && !bsp_s) || (start_cmd && load_mode))
      addr_d = addr_q + 3'h1; // [RQ15] [RQ8] [RQ17]
  end

  assign bkpt_d = !mclr_cmd && !load_mode && (addr_q == bkpt_sw); // [RQ16]

  // ----------------------------------------------------------------------
  // simulated write reply
  // ----------------------------------------------------------------------
  assign rep_set = itest_on && is_write && fwd_s && go_rise; // [RQ13]
  assign rep_clr = !itest_on || (!fwd_s && go_rise);
  assign rep_d = rep_set ? 1'b1 : (rep_clr ? 1'b0 : rep_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_q <= SEQ_IDLE;
      go_q <= 1'b0;
      addr_q <= 3'h0;
      bkpt_q <= 1'b0;
      rep_q <= 1'b0;
      dseen_q <= 1'b0;
      stop_q <= 1'b0;
      osc_start_q <= 1'b0;
      eoo_q <= 1'b0;
      instr_q <= INSTR_REWIND;
    end
    else
    begin
      seq_q <= seq_d;
      go_q <= go_d;
      addr_q <= addr_d;
      bkpt_q <= bkpt_d;
      rep_q <= rep_d;
      dseen_q <= dseen_d;
      stop_q <= stop_d;
      osc_start_q <= osc_start_d;
      eoo_q <= eoo_d;
      instr_q <= cur_instr; // [RQ18]
    end
  end

  // ----------------------------------------------------------------------
  // instruction store and loader
  // ----------------------------------------------------------------------
  assign sbus.addr = addr_q[1:0]; // [RQ7]
  assign sbus.we = load_we && load_mode;
  // new code in selected slot, other slot fed back
  assign sbus.wdata = addr_q[2] ? {load_code, sbus.rdata[1:0]} :
                                  {sbus.rdata[3:2], load_code}; // [RQ11]

  tepc_loader #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_loader
  (
    .clk(clk),
    .rst_n(rst_n),
    .load_mode(load_mode),
    .buttons(btn_s),
    .load_we(load_we),
    .load_code(load_code)
  );

  tepc_store u_store
  (
    .clk(clk),
    .rst_n(rst_n),
    .bus(sbus)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign osc_start = osc_start_q;
  assign stop_pulse = stop_q;
  assign end_of_op = eoo_q;
  assign go_request = go_q;
  assign instruction = instr_q;
  assign prog_addr = addr_q;
  assign breakpoint = bkpt_q;
  assign write_reply = itest_on ? rep_q : trep_s; // [RQ12]
  assign write_reply_lamp = write_reply; // [RQ14]
  assign set_write_term = write_reply && t3_s && !fwd_s; // [RQ14]

endmodule

// ==== test/tepc_transport_model.sv ====
// Purpose: transport timing seen by the program control
// Assumes: one operation per go request
// Notes: slow delays the transport end of operation
`timescale 1ns/1ps
module tepc_transport_model
(
  input wire logic clk,
  input wire logic slow,
  input wire logic go_request,
  input wire logic osc_start,
  input wire logic [1:0] instruction,
  input wire logic set_write_term,
  output logic go_pulse,
  output logic osc_out,
  output logic write_data_present,
  output logic write_ff_set,
  output logic write_term_run,
  output logic direction_fwd,
  output logic time3,
  output logic transport_eoo,
  output logic transport_write_reply
);
  // ----
  // operation timer
  // ----
  logic [7:0] t = 8'hff;
  logic wr = 1'b0;
  logic arm = 1'b0;
  logic term = 1'b0;
  wire logic [7:0] d = slow ? 8'h14 : 8'h00;
  initial direction_fwd = 1'b1;
  always @(posedge clk)
  begin
    if (go_request)
    begin
      t <= 8'h00;
      wr <= instruction == 2'h1;
      direction_fwd <= instruction != 2'h2;
      arm <= 1'b0;
      term <= 1'b0;
    end
    else if (t != 8'hff)
      t <= t + 8'h01;
    if (osc_start)
      arm <= 1'b1;
    if (set_write_term)
      term <= 1'b1;
  end
  assign go_pulse = t < 8'h06;
  assign write_ff_set = wr && t >= 8'h03 && t < 8'h3c;
  assign write_data_present = wr && t >= 8'h0c && t < 8'h1e;
  assign osc_out = arm && t >= 8'h28 && t < 8'h2e;
  assign write_term_run = term && t < 8'h14;
  assign time3 = t >= 8'h08 && t < 8'h0c;
  assign transport_eoo = t >= 8'h32 + d && t < 8'h36 + d;
  assign transport_write_reply = write_ff_set;
endmodule

// ==== test/tepc_assertions.sv ====
// Purpose: port checks for the program control
// Assumes: pins stay stable for several cycles
// Notes: bound into tepc_top
`timescale 1ns/1ps
module tepc_chk
  import tepc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic osc_out,
  input wire logic write_ff_set,
  input wire logic write_term_run,
  input wire logic go_pulse,
  input wire logic time3,
  input wire logic direction_fwd,
  input wire logic backspace,
  input wire logic osc_start,
  input wire logic stop_pulse,
  input wire logic end_of_op,
  input wire logic go_request,
  input wire logic [2:0] prog_addr,
  input wire logic breakpoint,
  input wire logic write_reply,
  input wire logic write_reply_lamp,
  input wire logic set_write_term
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic wr_done = psel && penable && pwrite;
  wire logic mapped = paddr == CTRL_OFS || paddr == CMD_OFS || paddr == STATUS_OFS;
  property addr_step;
    end_of_op && !$past(breakpoint) && !backspace |-> prog_addr == $past(prog_addr) + 3'h1;
  endproperty
  a_bus_error: assert property (psel && penable |-> pslverr == !mapped)
    else $error("bad pslverr");
  a_stop_gate: assert property (stop_pulse |-> !$past(write_ff_set, 3))
    else $error("stop while writing");
  a_stop_term: assert property (stop_pulse |-> !$past(write_term_run, 3))
    else $error("stop in write terminate");
  a_stop_osc: assert property (stop_pulse |-> $past(osc_out, 3) || $past(osc_out, 4))
    else $error("stop without oscillator");
  a_osc_cause: assert property (osc_start |-> $past(write_ff_set, 3) || $past(go_pulse, 3))
    else $error("oscillator start without cause");
  a_lamp_same: assert property (write_reply_lamp == write_reply)
    else $error("lamp differs from reply");
  a_term_reply: assert property (set_write_term |-> write_reply && $past(time3, 2) && !$past(direction_fwd, 2))
    else $error("terminate without reply");
  a_addr_step: assert property (addr_step)
    else $error("address did not step");
  a_addr_clear: assert property (end_of_op && $past(breakpoint) |-> prog_addr == 3'h0)
    else $error("address not cleared");
  a_addr_quiet: assert property ($changed(prog_addr) |-> end_of_op || $past(wr_done))
    else $error("address moved without cause");
  a_eoo_single: assert property (end_of_op |=> !end_of_op)
    else $error("end of operation too long");
  a_go_single: assert property (go_request |=> !go_request)
    else $error("go request too long");
  c_stop: cover property (stop_pulse);
  c_bkpt: cover property (end_of_op && breakpoint);
  c_reply: cover property (write_reply);
  c_err: cover property (pslverr);
endmodule
bind tepc_top tepc_chk u_chk (.*);

// ==== test/tb_tape_exerciser_program_control.sv ====
// Purpose: self-checking bench for the program control
// Assumes: short debounce count in simulation
// Notes: transport comes from the partner model; buttons and backspace are driven here
`timescale 1ns/1ps
module tb_tape_exerciser_program_control;
  import tepc_pkg::*;
  localparam int DEB = 8;
  logic clk = 0;
  logic nrst, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] instr_buttons;
  logic osc_out, write_data_present, write_ff_set, write_term_run, go_pulse;
  logic direction_fwd, time3, backspace, transport_eoo, transport_write_reply;
  logic osc_start, stop_pulse, end_of_op, go_request, breakpoint;
  logic write_reply, write_reply_lamp, set_write_term;
  logic [1:0] instruction;
  logic [2:0] prog_addr;
  int fail_count = 0, n_compared = 0, n_eoo = 0, n_stop = 0, n_osc = 0, max_a = 0;
  logic saw_wr = 0, saw_bk = 0;
  logic [1:0] code [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  int prog [8] = '{BTN_FORWARD, BTN_WRITE, BTN_REVERSE, BTN_REWIND,
    BTN_REVERSE, BTN_FORWARD, BTN_REWIND, BTN_WRITE};
  always #20 clk = ~clk;
  tepc_top #(.DEBOUNCE_CYC(DEB)) uut (.*);
  tepc_transport_model u_far (.*);
  // ----
  // monitors
  // ----
  always @(posedge clk)
  begin
    if (end_of_op === 1'b1) n_eoo++;
    if (stop_pulse === 1'b1) n_stop++;
    if (osc_start === 1'b1) n_osc++;
    if (write_reply === 1'b1) saw_wr = 1;
    if (breakpoint === 1'b1) saw_bk = 1;
    if (prog_addr > max_a) max_a = prog_addr;
  end
  // ----
  // helpers
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    n_compared++;
    if (got !== x)
    begin
      $display("unexpected %s expected %h seen %h", nm, x, got);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk("pslverr", xe, e);
  endtask
  task automatic press(input int b);
    instr_buttons <= 4'h1 << b;
    cyc(DEB + 40);
    instr_buttons <= 4'h0;
    cyc(40);
  endtask
  task automatic wait_eoo(input int e0);
    for (int i = 0; i < 400 && n_eoo == e0; i++) @(posedge clk);
    cyc(150);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd("ctrl", CTRL_OFS, 32'h0, 1'b0);
    wr(CTRL_OFS, 32'h75);
    rd("ctrl", CTRL_OFS, 32'h75, 1'b0);
    rd("cmd", CMD_OFS, 32'h0, 1'b0);
    rd("hole", 8'h0c, 32'h0, 1'b1);
    wr(CTRL_OFS, 32'h0);
  endtask
  task automatic t_load();
    for (int i = 0; i < 8; i++)
    begin
      press(prog[i]);
      wr(CMD_OFS, 32'h1);
    end
    wr(CTRL_OFS, 32'h1);
    press(BTN_REVERSE);
    wr(CTRL_OFS, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      cyc(4);
      chk("addr", i, prog_addr);
      chk("instr", code[prog[i]], instruction);
      wr(CMD_OFS, 32'h1);
    end
    cyc(4);
    chk("addr", 0, prog_addr);
  endtask
  task automatic t_step();
    int e0, s0, o0;
    wr(CTRL_OFS, 32'h75);
    for (int k = 0; k < 4; k++)
    begin
      e0 = n_eoo;
      s0 = n_stop;
      o0 = n_osc;
      wr(CMD_OFS, 32'h1);
      wait_eoo(e0);
      chk("eoo count", e0 + 1, n_eoo);
      chk("addr", k + 1, prog_addr);
      chk("osc", o0 + 1, n_osc);
      chk("stop", s0 + (k == 1 ? 0 : 1), n_stop);
    end
    chk("reply", 1'b1, saw_wr);
    rd("status", STATUS_OFS, 32'h24, 1'b0);
  endtask
  task automatic t_run();
    int e0;
    wr(CMD_OFS, 32'h2);
    cyc(4);
    chk("addr", 0, prog_addr);
    max_a = 0;
    saw_bk = 0;
    e0 = n_eoo;
    wr(CTRL_OFS, 32'h2a);
    wr(CMD_OFS, 32'h1);
    cyc(800);
    chk("max addr", 2, max_a);
    chk("bkpt", 1, saw_bk);
    chk("repeat", 1, n_eoo - e0 > 5);
    wr(CTRL_OFS, 32'h28);
    cyc(100);
    e0 = n_eoo;
    cyc(300);
    chk("stopped", e0, n_eoo);
  endtask
  task automatic t_off();
    int e0, o0;
    wr(CMD_OFS, 32'h2);
    slow <= 1'b1;
    wr(CTRL_OFS, 32'h71);
    e0 = n_eoo;
    o0 = n_osc;
    wr(CMD_OFS, 32'h1);
    wait_eoo(e0);
    chk("eoo count", e0 + 1, n_eoo);
    chk("addr", 1, prog_addr);
    chk("osc", o0, n_osc);
    chk("reply", 1'b0, write_reply);
    backspace <= 1'b1;
    e0 = n_eoo;
    wr(CMD_OFS, 32'h1);
    wait_eoo(e0);
    chk("eoo count", e0 + 1, n_eoo);
    chk("addr", 1, prog_addr);
    backspace <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #800000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    nrst = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    instr_buttons = 0;
    backspace = 0;
    slow = 0;
    cyc(16);
    nrst <= 1'b1;
    cyc(4);
    t_regs();
    t_load();
    t_step();
    t_run();
    t_off();
    print_verdict();
  end
endmodule
